// ---- common/cmd_timing_params.svh ----
`ifndef CMD_TIMING_PARAMS_SVH
`define CMD_TIMING_PARAMS_SVH
// ==========================================================
// clock and conversion
`define CLK_PS          100000
`define NS2CK(ns_x10, ck) (((((ns_x10) * 100) + `CLK_PS - 1) / `CLK_PS) > (ck) ? \
  ((((ns_x10) * 100) + `CLK_PS - 1) / `CLK_PS) : (ck))
// ==========================================================
// times in tenths of a nanosecond, cycle minimums
`define T_CKE_NS10      75
`define T_CKE_CK        3
`define T_CPDED_CK      2
`define T_MRW_CK        10
`define T_MRR_CK        4
`define T_CKESR_NS10    150
`define T_CKESR_CK      3
`define T_XSR_ADD_NS10  100
`define T_XSR_CK        2
`define T_RFCAB_NS10    1300
`define T_XP_NS10       75
`define T_XP_CK         3
`define T_RTP_NS10      75
`define T_RTP_CK        4
`define T_RCD_NS10      180
`define T_RCD_CK        3
`define T_RPPB_NS10     180
`define T_RPPB_CK       3
`define T_RPAB_NS10     210
`define T_RPAB_CK       3
`define T_RAS_NS10      420
`define T_RAS_CK        3
`define RL_CK           12
`define WL_CK           6
`define DQSS_LIMIT_CK   1
// ==========================================================
// command codes on the user port
`define OP_NOP          3'h0
`define OP_ACT          3'h1
`define OP_RD           3'h2
`define OP_WR           3'h3
`define OP_PRE          3'h4
`define OP_PREA         3'h5
`define OP_MRW          3'h6
`define OP_MRR          3'h7
`define NBANK           8
`define CNT_W           8
`endif

// ---- common/cmd_timing_pkg.sv ----
`default_nettype none
`include "cmd_timing_params.svh"
package cmd_timing_pkg;
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_ISSUE  = 6'h02,
    ST_PDWAIT = 6'h04,
    ST_PDOWN  = 6'h08,
    ST_SREF   = 6'h10,
    ST_EXIT   = 6'h20
  } ctl_state_type;
  typedef logic [`CNT_W-1:0] cnt_type;
endpackage
`default_nettype wire

// ---- hw/data_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module data_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  // fill side
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_ready,
  // drain side
  output logic                  o_valid,
  output logic [WIDTH-1:0]      o_data,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        rdy;
  } fifo_type;
  fifo_type s_q;
  fifo_type s_d;
  logic     push;
  logic     pop;
  // ==========================================================
  // handshake and next state
  always_comb begin
    push = i_valid && s_q.rdy;
    pop  = i_ready && (s_q.cnt != '0);
    s_d  = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = i_data;
      s_d.wr          = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_d.rdy = s_d.cnt != (AW+1)'(DEPTH); // registered fill-side ready
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign o_ready = s_q.rdy;
  assign o_valid = s_q.cnt != '0;
  assign o_data  = s_q.mem[s_q.rd];
endmodule
`default_nettype wire

// ---- hw/lpddr_cmd_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "cmd_timing_params.svh"
module lpddr_cmd_ctrl
  import cmd_timing_pkg::*;
#(
  parameter int RFCAB_NS10 = `T_RFCAB_NS10
) (
  // system clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // link clock
  input  wire logic        i_clk_link,
  // user command port
  input  wire logic        i_cmd_valid,
  input  wire logic [2:0]  i_cmd_op,
  input  wire logic [2:0]  i_cmd_bank,
  input  wire logic [15:0] i_cmd_addr,
  output logic             o_cmd_ready,
  // user power requests
  input  wire logic        i_pd_req,
  input  wire logic        i_sref_req,
  output logic             o_low_power,
  // user write data
  input  wire logic        i_wdata_valid,
  input  wire logic [31:0] i_wdata,
  output logic             o_wdata_ready,
  // memory pins
  output logic             o_cke,
  output logic             o_cs_n,
  output logic [2:0]       o_mem_op,
  output logic [2:0]       o_mem_bank,
  output logic [15:0]      o_mem_addr,
  output logic [31:0]      o_dq_out,
  output logic             o_dq_oe_n,
  output logic             o_dqs_out,
  output logic             o_dqs_oe_n,
  // read data from the link domain
  input  wire logic [31:0] i_dq_in,
  output logic [31:0]      o_rdata,
  output logic             o_rdata_valid
);
  // ==========================================================
  // derived cycle counts
  localparam cnt_type C_CKE   = cnt_type'(`NS2CK(`T_CKE_NS10, `T_CKE_CK));
  localparam cnt_type C_CKESR = cnt_type'(`NS2CK(`T_CKESR_NS10, `T_CKESR_CK));
  localparam cnt_type C_XP    = cnt_type'(`NS2CK(`T_XP_NS10, `T_XP_CK));
  localparam cnt_type C_XSR   = cnt_type'(`NS2CK(RFCAB_NS10 + `T_XSR_ADD_NS10, `T_XSR_CK));
  localparam cnt_type C_RCD   = cnt_type'(`NS2CK(`T_RCD_NS10, `T_RCD_CK));
  localparam cnt_type C_RTP   = cnt_type'(`NS2CK(`T_RTP_NS10, `T_RTP_CK));
  localparam cnt_type C_RPPB  = cnt_type'(`NS2CK(`T_RPPB_NS10, `T_RPPB_CK));
  localparam cnt_type C_RPAB  = cnt_type'(`NS2CK(`T_RPAB_NS10, `T_RPAB_CK));
  localparam cnt_type C_RAS   = cnt_type'(`NS2CK(`T_RAS_NS10, `T_RAS_CK));
  localparam cnt_type C_MRW   = cnt_type'(`T_MRW_CK);
  localparam cnt_type C_MRR   = cnt_type'(`T_MRR_CK);
  localparam cnt_type C_CPD   = cnt_type'(`T_CPDED_CK);
  localparam cnt_type C_RL    = cnt_type'(`RL_CK);
  localparam cnt_type C_WL    = cnt_type'(`WL_CK);

  typedef struct packed {
    ctl_state_type                state;
    logic                         cke;
    logic                         cs_n;
    logic [2:0]                   op;
    logic [2:0]                   bank;
    logic [15:0]                  addr;
    cnt_type                      cke_hold;   // cke level hold countdown
    cnt_type                      gap;        // global command gap
    cnt_type                      mrr_gap;    // extra gap before mode read
    logic [`NBANK-1:0][`CNT_W-1:0] act_cnt;
    logic [`NBANK-1:0][`CNT_W-1:0] pre_cnt;
    logic [`NBANK-1:0][`CNT_W-1:0] ras_cnt;
    logic                         low_power;
    logic                         in_sref;
    cnt_type                      wl_cnt;     // write latency countdown
    logic                         wr_burst;
    logic                         dq_oe_n;
    logic [31:0]                  dq;
    logic                         rd_tgl;     // read event toward link
    logic                         ready;
  } ctl_type;
  ctl_type s_q;
  ctl_type s_d;

  logic        fifo_valid;
  logic [31:0] fifo_data;
  logic        fifo_pop;

  // write data buffer, back-pressure to user
  data_fifo #(.WIDTH(32), .DEPTH(4)) u_wfifo (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_valid   (i_wdata_valid),
    .i_data    (i_wdata),
    .o_ready   (o_wdata_ready),
    .o_valid   (fifo_valid),
    .o_data    (fifo_data),
    .i_ready   (fifo_pop)
  );

  // decrement saturating at zero
  function automatic logic [`CNT_W-1:0] dec(input logic [`CNT_W-1:0] v);
    return (v == '0) ? v : v - 1'b1;
  endfunction

  function automatic logic [`CNT_W-1:0] maxc(input logic [`CNT_W-1:0] a,
                                             input logic [`CNT_W-1:0] b);
    return (a > b) ? a : b;
  endfunction

  logic can_issue;
  // ==========================================================
  // command scheduling and power state
  always_comb begin
    s_d          = s_q;
    s_d.cs_n     = 1'b1;
    s_d.op       = `OP_NOP;
    s_d.cke_hold = dec(s_q.cke_hold);
    s_d.gap      = dec(s_q.gap);
    s_d.mrr_gap  = dec(s_q.mrr_gap);
    s_d.wl_cnt   = dec(s_q.wl_cnt);
    fifo_pop     = 1'b0;
    for (int b = 0; b < `NBANK; b++) begin
      s_d.act_cnt[b] = dec(s_q.act_cnt[b]);
      s_d.pre_cnt[b] = dec(s_q.pre_cnt[b]);
      s_d.ras_cnt[b] = dec(s_q.ras_cnt[b]);
    end
    // per-bank and global holds
    can_issue = (s_q.gap == '0);
    case (i_cmd_op)
      `OP_ACT:  can_issue = can_issue && (s_q.act_cnt[i_cmd_bank] == '0);
      `OP_PRE:  can_issue = can_issue && (s_q.pre_cnt[i_cmd_bank] == '0);
      `OP_PREA: can_issue = can_issue && (s_q.pre_cnt == '0);
      `OP_MRR:  can_issue = can_issue && (s_q.mrr_gap == '0);
      `OP_WR:   can_issue = can_issue && fifo_valid && (s_q.wl_cnt == '0);
      default:  can_issue = can_issue;
    endcase
    s_d.ready = 1'b0;
    case (s_q.state)
      ST_IDLE: begin
        if ((i_pd_req || i_sref_req) && s_q.gap == '0 && s_q.cke_hold == '0 &&
            !s_q.wr_burst && s_q.wl_cnt == '0) begin
          s_d.cke      = 1'b0;
          s_d.cke_hold = maxc(C_CKE, i_sref_req ? C_CKESR : C_CKE);
          s_d.gap      = C_CPD;
          s_d.in_sref  = i_sref_req;
          s_d.state    = ST_PDWAIT;
        end else if (i_cmd_valid && can_issue && i_cmd_op != `OP_NOP) begin
          s_d.ready = 1'b1;
          s_d.state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        // command taken, driven on pins next cycle
        s_d.cs_n   = 1'b0;
        s_d.op     = i_cmd_op;
        s_d.bank   = i_cmd_bank;
        s_d.addr   = i_cmd_addr;
        s_d.gap    = cnt_type'(1);
        s_d.state  = ST_IDLE;
        case (i_cmd_op)
          `OP_ACT: begin
            s_d.ras_cnt[i_cmd_bank] = C_RAS;
            s_d.act_cnt[i_cmd_bank] = C_RAS + C_RPPB;
            s_d.pre_cnt[i_cmd_bank] = C_RAS;
          end
          `OP_RD: begin
            s_d.pre_cnt[i_cmd_bank] = maxc(s_q.pre_cnt[i_cmd_bank], C_RTP);
            s_d.rd_tgl = ~s_q.rd_tgl;
          end
          `OP_WR: begin
            s_d.wl_cnt = C_WL;
          end
          `OP_PRE: begin
            s_d.act_cnt[i_cmd_bank] = maxc(s_q.act_cnt[i_cmd_bank], C_RPPB);
          end
          `OP_PREA: begin
            for (int b = 0; b < `NBANK; b++) begin
              s_d.act_cnt[b] = maxc(s_q.act_cnt[b], C_RPAB);
            end
          end
          `OP_MRW: s_d.gap = C_MRW;
          `OP_MRR: s_d.gap = C_MRR;
          default: s_d.gap = cnt_type'(1);
        endcase
      end
      ST_PDWAIT: begin
        // deselect only while the command path shuts down
        if (s_q.gap == '0) begin
          s_d.low_power = 1'b1;
          s_d.state     = s_q.in_sref ? ST_SREF : ST_PDOWN;
        end
      end
      ST_PDOWN, ST_SREF: begin
        if (!(s_q.in_sref ? i_sref_req : i_pd_req) && s_q.cke_hold == '0) begin
          s_d.cke       = 1'b1;
          s_d.cke_hold  = C_CKE;
          s_d.gap       = s_q.in_sref ? C_XSR : C_XP;
          s_d.mrr_gap   = s_q.in_sref ? C_XSR : C_XP + C_RCD;
          s_d.state     = ST_EXIT;
        end
      end
      ST_EXIT: begin
        if (s_q.gap == '0) begin
          s_d.low_power = 1'b0;
          s_d.in_sref   = 1'b0;
          s_d.state     = ST_IDLE;
        end
      end
      default: s_d.state = ST_IDLE;
    endcase
    // write data out at the latency point, strobe within a clock
    s_d.dq_oe_n  = 1'b1;
    s_d.wr_burst = 1'b0;
    if (s_q.wl_cnt == cnt_type'(1) && fifo_valid) begin
      fifo_pop     = 1'b1;
      s_d.dq       = fifo_data;
      s_d.dq_oe_n  = 1'b0;
      s_d.wr_burst = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      s_q       <= '0;
      s_q.state <= ST_IDLE;
      s_q.cke   <= 1'b1;
      s_q.cs_n  <= 1'b1;
      s_q.dq_oe_n <= 1'b1;
      s_q.cke_hold <= C_CKE;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_cmd_ready = s_q.ready;
  assign o_low_power = s_q.low_power;
  assign o_cke       = s_q.cke;
  assign o_cs_n      = s_q.cs_n;
  assign o_mem_op    = s_q.op;
  assign o_mem_bank  = s_q.bank;
  assign o_mem_addr  = s_q.addr;
  assign o_dq_out    = s_q.dq;
  assign o_dq_oe_n   = s_q.dq_oe_n;
  assign o_dqs_out   = s_q.wr_burst;
  assign o_dqs_oe_n  = s_q.dq_oe_n;

  // ==========================================================
  // link domain: read capture after read latency
  typedef struct packed {
    logic [2:0]  tgl_sync;
    cnt_type     rl_cnt;
    logic        busy;
    logic [31:0] data;
    logic        done_tgl;
  } link_type;
  link_type l_q;
  link_type l_d;

  always_comb begin
    l_d          = l_q;
    l_d.tgl_sync = {l_q.tgl_sync[1:0], s_q.rd_tgl};
    if (l_q.tgl_sync[2] != l_q.tgl_sync[1]) begin
      l_d.rl_cnt = C_RL;
      l_d.busy   = 1'b1;
    end else if (l_q.busy) begin
      l_d.rl_cnt = dec(l_q.rl_cnt);
      if (l_q.rl_cnt == cnt_type'(1)) begin
        l_d.data     = i_dq_in;
        l_d.done_tgl = ~l_q.done_tgl;
        l_d.busy     = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_link) begin
    if (!i_reset_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // ==========================================================
  // return read word to system domain
  typedef struct packed {
    logic [2:0]  sync;
    logic [31:0] data;
    logic        valid;
  } ret_type;
  ret_type r_q;
  ret_type r_d;

  always_comb begin
    r_d       = r_q;
    r_d.sync  = {r_q.sync[1:0], l_q.done_tgl};
    r_d.valid = r_q.sync[2] != r_q.sync[1];
    if (r_q.sync[2] != r_q.sync[1]) begin
      r_d.data = l_q.data; // stable since toggle
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_rdata       = r_q.data;
  assign o_rdata_valid = r_q.valid;
endmodule
`default_nettype wire

// ---- bench/lpddr_cmd_ctrl_props.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "cmd_timing_params.svh"
module lpddr_cmd_ctrl_chk
  import cmd_timing_pkg::*;
#(
  parameter int RFCAB_NS10 = `T_RFCAB_NS10
) (
  // clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_reset_n,
  // memory pins
  input wire logic       o_cke,
  input wire logic       o_cs_n,
  input wire logic [2:0] o_mem_op,
  input wire logic [2:0] o_mem_bank,
  input wire logic       o_dq_oe_n,
  input wire logic       o_dqs_out
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // =====
  // command decode
  logic       cmd;
  logic [3:0] mrw_left;
  assign cmd = !o_cs_n;
  // cycles still closed to commands after a mode write
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      mrw_left <= 4'h0;
    end else if (cmd && o_mem_op == `OP_MRW) begin
      mrw_left <= 4'h9;
    end else if (mrw_left != 4'h0) begin
      mrw_left <= mrw_left - 4'h1;
    end
  end
  sequence s_wr;
    cmd && o_mem_op == `OP_WR;
  endsequence
  sequence s_strobe;
    !o_dq_oe_n && o_dqs_out;
  endsequence
  // =====
  // properties
  chk_wr_strobe_time: assert property (s_wr |-> ##6 s_strobe)
    else $error("write strobe not at write latency");
  chk_cke_high_hold: assert property ($rose(o_cke) |=> o_cke [*2])
    else $error("clock enable high too short");
  chk_cke_low_hold: assert property ($fell(o_cke) |=> !o_cke [*2])
    else $error("clock enable low too short");
  chk_cpded_deselect: assert property ($fell(o_cke) |-> o_cs_n [*3])
    else $error("command during path disable");
  chk_mrw_gap: assert property (mrw_left != 4'h0 |-> o_cs_n)
    else $error("command too soon after mode write");
  chk_mrr_gap: assert property (cmd && o_mem_op == `OP_MRR |=> o_cs_n [*3])
    else $error("command too soon after mode read");
  chk_exit_wait: assert property ($rose(o_cke) |-> o_cs_n [*3])
    else $error("command too soon after exit");
  chk_rd_pre_gap: assert property (cmd && o_mem_op == `OP_RD |-> ##3
    !(cmd && o_mem_op == `OP_PRE && o_mem_bank == $past(o_mem_bank, 3)))
    else $error("precharge too soon after read");
  chk_cmd_gap: assert property (cmd |=> o_cs_n [*2])
    else $error("commands closer than three cycles");
endmodule
bind lpddr_cmd_ctrl lpddr_cmd_ctrl_chk #(.RFCAB_NS10(RFCAB_NS10)) chk_u (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .o_cke(o_cke), .o_cs_n(o_cs_n),
  .o_mem_op(o_mem_op), .o_mem_bank(o_mem_bank), .o_dq_oe_n(o_dq_oe_n),
  .o_dqs_out(o_dqs_out));
`default_nettype wire

// ---- bench/lpddr_dev_model.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "cmd_timing_params.svh"
module lpddr_dev_model
  import cmd_timing_pkg::*;
#(
  parameter int RL = `RL_CK
) (
  // capture clock
  input wire logic        i_clk_link,
  // command pins
  input wire logic        i_cke,
  input wire logic        i_cs_n,
  input wire logic [2:0]  i_op,
  input wire logic [2:0]  i_bank,
  input wire logic [15:0] i_addr,
  // read data
  output logic [31:0]     o_dq
);
  logic        cs_n_q = 1'b1;
  logic [31:0] pat_q = 32'h0;
  logic [31:0] dq_q = 32'h0;
  int          age_q = 1000;
  assign o_dq = dq_q;
  // read command at the pins restarts the latency count
  always @(posedge i_clk_link) begin
    cs_n_q <= i_cs_n;
    if (cs_n_q && !i_cs_n && i_cke && i_op == `OP_RD) begin
      pat_q <= {i_addr, 13'h0a5, i_bank};
      age_q <= 0;
    end else if (age_q < 1000) begin
      age_q <= age_q + 1;
    end
  end
  // data stands around the latency point, toggles elsewhere
  always @(posedge i_clk_link) begin
    if (age_q >= RL - 8 && age_q <= RL + 12) begin
      dq_q <= pat_q;
    end else begin
      dq_q <= ~dq_q;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_lpddr_cmd_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "cmd_timing_params.svh"
module tb_lpddr_cmd_ctrl
  import cmd_timing_pkg::*;
;
  logic        clk_sys = 1'b0, clk_link = 1'b0, reset_n = 1'b0, cke_q = 1'b1;
  logic        cmd_valid, pd_req, sref_req, wdata_valid, cmd_ready, low_power;
  logic        wdata_ready, cke, cs_n, dq_oe_n, dqs_out, dqs_oe_n, rdata_valid;
  logic [2:0]  cmd_op, cmd_bank, mem_op, mem_bank, last_op;
  logic [15:0] cmd_addr, mem_addr;
  logic [31:0] wdata, dq_in, rdata, dq_out;
  logic [31:0] wq[$], rq[$];
  int          n_mismatch = 0, checks = 0, cyc = 0, last_cmd = -100, last_prea = -100;
  int          cke_edge = -100, last_act[8], last_pre[8], last_rd[8];
  // clocks, unrelated in phase
  initial forever #50 clk_sys = ~clk_sys;
  initial begin
    #3.7;
    forever #6 clk_link = ~clk_link;
  end
  lpddr_cmd_ctrl #(.RFCAB_NS10(10)) dut_u (
    .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_clk_link(clk_link),
    .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_bank(cmd_bank),
    .i_cmd_addr(cmd_addr), .o_cmd_ready(cmd_ready), .i_pd_req(pd_req),
    .i_sref_req(sref_req), .o_low_power(low_power), .i_wdata_valid(wdata_valid),
    .i_wdata(wdata), .o_wdata_ready(wdata_ready), .o_cke(cke), .o_cs_n(cs_n),
    .o_mem_op(mem_op), .o_mem_bank(mem_bank), .o_mem_addr(mem_addr),
    .o_dq_out(dq_out), .o_dq_oe_n(dq_oe_n), .o_dqs_out(dqs_out), .o_dqs_oe_n(dqs_oe_n),
    .i_dq_in(dq_in), .o_rdata(rdata), .o_rdata_valid(rdata_valid));
  lpddr_dev_model dev_u (
    .i_clk_link(clk_link), .i_cke(cke), .i_cs_n(cs_n), .i_op(mem_op),
    .i_bank(mem_bank), .i_addr(mem_addr), .o_dq(dq_in));
  // =====
  // checking helpers
  function automatic logic [31:0] pat(input logic [2:0] b, input logic [15:0] a);
    return {a, 13'h0a5, b};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic at_least(input int gap, input int lim);
    check(32'(gap >= lim), 32'h1);
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // =====
  // drivers
  task automatic issue(input logic [2:0] op, input logic [2:0] b, input logic [15:0] a);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_bank = b;
    cmd_addr = a;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cmd_ready !== 1'b1 && n < 300);
    check(32'(cmd_ready), 32'h1);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    check(32'({cs_n, mem_op, mem_bank, mem_addr}), 32'({1'b0, op, b, a}));
    @(negedge clk_sys);
  endtask
  task automatic put_word(input logic [31:0] w);
    check(32'(wdata_ready), 32'h1);
    wdata_valid = 1'b1;
    wdata = w;
    wq.push_back(w);
    @(negedge clk_sys);
  endtask
  task automatic power(input logic sr);
    int n;
    pd_req = !sr;
    sref_req = sr;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (low_power !== 1'b1 && n < 50);
    check(32'({low_power, cke}), 32'h2);
    repeat (4) @(negedge clk_sys);
    pd_req = 1'b0;
    sref_req = 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (low_power !== 1'b0 && n < 50);
    check(32'({low_power, cke}), 32'h1);
  endtask
  // pin monitor: spacing, write data, read data, time limit
  always @(negedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
    if (reset_n) begin
      if (cke !== cke_q) begin
        at_least(cyc - cke_edge, 3);
        cke_edge = cyc;
      end
      cke_q = cke;
      if (cs_n === 1'b0) begin
        at_least(cyc - last_cmd, last_op == `OP_MRW ? 10 : last_op == `OP_MRR ? 4 : 3);
        at_least(cyc - cke_edge, 3);
        if (mem_op == `OP_ACT) begin
          at_least(cyc - last_act[mem_bank], 6);
          at_least(cyc - last_pre[mem_bank], 3);
          at_least(cyc - last_prea, 3);
          last_act[mem_bank] = cyc;
        end
        if (mem_op == `OP_PRE) begin
          at_least(cyc - last_rd[mem_bank], 4);
          last_pre[mem_bank] = cyc;
        end
        if (mem_op == `OP_PREA) last_prea = cyc;
        if (mem_op == `OP_RD) begin
          last_rd[mem_bank] = cyc;
          rq.push_back(pat(mem_bank, mem_addr));
        end
        last_cmd = cyc;
        last_op = mem_op;
      end
      if (dq_oe_n === 1'b0) begin
        check(dq_out, wq.pop_front());
        check(32'({dqs_out, dqs_oe_n}), 32'h2);
      end else begin
        check(32'({dqs_out, dqs_oe_n}), 32'h1);
      end
      if (rdata_valid === 1'b1) check(rdata, rq.pop_front());
    end
  end
  // =====
  // main sequence
  initial begin
    logic [2:0] op;
    logic [2:0] b;
    {cmd_valid, pd_req, sref_req, wdata_valid, cmd_op, cmd_bank, cmd_addr, wdata} = '0;
    last_op = `OP_NOP;
    foreach (last_act[k]) begin
      last_act[k] = -100;
      last_pre[k] = -100;
      last_rd[k] = -100;
    end
    void'($urandom(32'he285));
    repeat (3) @(negedge clk_sys);
    check(32'({cke, cs_n, dq_oe_n, cmd_ready}), 32'he);
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    // fill until refused, then drain by back-to-back writes
    repeat (4) put_word($urandom);
    wdata = 32'hdead0bad;
    @(negedge clk_sys);
    check(32'(wdata_ready), 32'h0);
    wdata_valid = 1'b0;
    repeat (4) issue(`OP_WR, 3'($urandom), 16'($urandom));
    // every command code but NOP once
    for (int k = 1; k < 8; k++) begin
      if (k == `OP_WR) begin
        put_word($urandom);
        wdata_valid = 1'b0;
      end
      issue(3'(k), 3'($urandom), 16'($urandom));
    end
    // power states, each followed at once by commands
    power(1'b0);
    issue(`OP_ACT, 3'h2, 16'h0000);
    power(1'b1);
    issue(`OP_MRR, 3'h0, 16'hffff);
    issue(`OP_RD, 3'h2, 16'h1234);
    issue(`OP_PRE, 3'h2, 16'h0000);
    issue(`OP_ACT, 3'h2, 16'h0000);
    issue(`OP_ACT, 3'h2, 16'h0001);
    issue(`OP_PREA, 3'h0, 16'h0000);
    issue(`OP_ACT, 3'h7, 16'h0000);
    // random command stream
    repeat (24) begin
      op = 3'($urandom_range(7, 1));
      b = 3'($urandom);
      if (op == `OP_WR) op = `OP_RD;
      issue(op, b, 16'($urandom));
    end
    repeat (40) @(negedge clk_sys);
    check(32'(rq.size() + wq.size()), 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
